// File: inductive_conversion_control_defs.svh
// register map, field positions, reset values and timing counts
// assumes a byte-wide register port and a 200 MHz system clock
`ifndef INDUCTIVE_CONVERSION_CONTROL_DEFS_SVH
`define INDUCTIVE_CONVERSION_CONTROL_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define A_DRIVE_RANGE   8'h01
`define A_TIME_CONST    8'h03
`define A_DIG_CFG       8'h04
`define A_ALT_CFG       8'h05
`define A_DRIVE_CFG     8'h0C
`define A_STATUS        8'h20
`define A_REF_CYCLE_COUNT_LO     8'h30
`define A_REF_CYCLE_COUNT_HI     8'h31
`define A_OFFSET_LO     8'h32
`define A_OFFSET_HI     8'h33
`define A_HIRES_CFG     8'h34
`define A_RESULT_LO     8'h38
`define A_RESULT_MID    8'h39
`define A_RESULT_HI     8'h3A

// ----------------------------------------
// fields, resets and counts
// ----------------------------------------
`define STATUS_LOST_BIT 7
`define HQ_TANK_BIT     7
`define FIXED_BIT       0
`define REG_RST         8'h00
`define RESULT_LOST     24'hFFFFFF
`define RESULT_NONE     24'h000000
`define WDOG_STEPS      16
`define RPL_MIN_CYC     192
`define RPL_DIV         3
`define RPL_MAX_SHIFT   3'h5
`define HR_MULT_SHIFT   4
`define HR_POST_CYC     55
`define OFFSET_SHIFT    8

`endif

// File: inductive_conversion_control_pkg.sv
// state types of the conversion-control block
// assumes the constants header supplies the numeric values
package inductive_conversion_control_pkg;

    typedef enum logic [1:0] {
        HR_IDLE  = 2'b00,
        HR_COUNT = 2'b01,
        HR_POST  = 2'b10
    } hires_state_e;

    typedef struct packed {
        logic         sensSync1;
        logic         sensSync2;
        logic         sensPrev;
        logic         refSync1;
        logic         refSync2;
        logic         refPrev;
        logic [7:0]   driveRange;
        logic [7:0]   timeConst;
        logic [7:0]   digCfg;
        logic [7:0]   altCfg;
        logic [7:0]   drvCfg;
        logic [15:0]  ref_cycle_count;
        logic [15:0]  offset;
        logic [7:0]   hiresCfg;
        logic         oscLost;
        logic [19:0]  wdCnt;
        logic [19:0]  kickCnt;
        logic [15:0]  refIdle;
        logic         refPresent;
        logic [11:0]  rplCnt;
        logic [15:0]  rplRef;
        logic [15:0]  lResult;
        logic         rplDone;
        hires_state_e hrState;
        logic [20:0]  hrRef;
        logic [20:0]  hrSens;
        logic [2:0]   divCnt;
        logic [23:0]  hrResult;
        logic         hrDone;
        logic [7:0]   rdData;
    } ctrl_state_s;

endpackage : inductive_conversion_control_pkg

// File: inductive_conversion_control.sv
// conversion control: watchdog, sample timing, drive settings
// assumes sensor and reference clock arrive as asynchronous pins
`timescale 1ns/10ps
`include "inductive_conversion_control_defs.svh"

module inductive_conversion_control #(
    parameter int unsigned WDOG_UNIT   = 4096,
    parameter int unsigned KICK_UNIT   = 256,
    parameter int unsigned REF_TIMEOUT = 400
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        activeMode,
    input  wire logic        sensorOsc,
    input  wire logic        refClkIn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    output logic             oscLost,
    output logic             oscRestart,
    output logic             oscKick,
    output logic             rpModEnable,
    output logic      [2:0]  driveCode,
    output logic             highQualityTank,
    output logic      [4:0]  tc1Res,
    output logic      [5:0]  tc2Res,
    output logic      [1:0]  tcCap,
    output logic             rplDone,
    output logic      [15:0] lResult,
    output logic             hiresDone,
    output logic      [23:0] hiresResult
);

    // ----------------------------------------
    // state and decoded terms
    // ----------------------------------------
    inductive_conversion_control_pkg::ctrl_state_s st_reg;
    inductive_conversion_control_pkg::ctrl_state_s st_next;

    logic        sensEdge;
    logic        refEdge;
    logic        wdFire;
    logic [19:0] wdLimit;
    logic [19:0] kickLen;
    logic [2:0]  rplShift;
    logic [11:0] rplLimit;
    logic [20:0] hrLimit;
    logic [2:0]  divMask;
    logic [23:0] hrValue;
    logic        fixedMode;

    // only the second sync stage feeds edge detection
    assign sensEdge = st_reg.sensSync2 & ~st_reg.sensPrev;
    assign refEdge  = st_reg.refSync2 & ~st_reg.refPrev;

    // lower frequency code stretches the watchdog wait
    assign wdLimit = 20'(WDOG_UNIT * (`WDOG_STEPS
                     - int'(st_reg.digCfg[7:4])));

    // startup kick also scales with the same setting
    assign kickLen = 20'(KICK_UNIT * (`WDOG_STEPS
                     - int'(st_reg.digCfg[7:4])));

    assign wdFire = activeMode & ~sensEdge
                    & (st_reg.wdCnt >= wdLimit - 20'h00001);

    // codes above the top setting saturate at 6144 cycles
    assign rplShift = (st_reg.digCfg[2:0] > `RPL_MAX_SHIFT)
                      ? `RPL_MAX_SHIFT
                      : st_reg.digCfg[2:0];

    // sensor edges counted are the cycle count over three
    assign rplLimit = 12'(`RPL_MIN_CYC / `RPL_DIV)
                      << rplShift;

    assign hrLimit = 21'(st_reg.ref_cycle_count)
                     << `HR_MULT_SHIFT;

    assign divMask = 3'((1 << st_reg.hiresCfg[1:0]) - 1);

    // exact scaling needs a divider; the shift is exact
    // only at full reference count, traded for area
    assign hrValue = 24'({st_reg.hrSens[19:0],
                          4'h0})
                     - 24'({st_reg.offset,
                            8'h00});

    assign fixedMode = st_reg.altCfg[`FIXED_BIT]
                       & st_reg.drvCfg[`FIXED_BIT];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;

        st_next.sensSync1 = sensorOsc;
        st_next.sensSync2 = st_reg.sensSync1;
        st_next.sensPrev  = st_reg.sensSync2;
        st_next.refSync1  = refClkIn;
        st_next.refSync2  = st_reg.refSync1;
        st_next.refPrev   = st_reg.refSync2;
        st_next.rplDone   = 1'b0;
        st_next.hrDone    = 1'b0;

        // register writes
        if (regWrite) begin
            if (regAddr == `A_DRIVE_RANGE) begin
                st_next.driveRange = regWrData;
            end else if (regAddr == `A_TIME_CONST) begin
                st_next.timeConst = regWrData;
            end else if (regAddr == `A_DIG_CFG) begin
                st_next.digCfg = regWrData;
            end else if (regAddr == `A_ALT_CFG) begin
                st_next.altCfg = regWrData;
            end else if (regAddr == `A_DRIVE_CFG) begin
                st_next.drvCfg = regWrData;
            end else if (regAddr == `A_REF_CYCLE_COUNT_LO) begin
                st_next.ref_cycle_count[7:0] = regWrData;
            end else if (regAddr == `A_REF_CYCLE_COUNT_HI) begin
                st_next.ref_cycle_count[15:8] = regWrData;
            end else if (regAddr == `A_OFFSET_LO) begin
                st_next.offset[7:0] = regWrData;
            end else if (regAddr == `A_OFFSET_HI) begin
                st_next.offset[15:8] = regWrData;
            end else if (regAddr == `A_HIRES_CFG) begin
                st_next.hiresCfg = regWrData;
            end
        end

        // register reads, registered one cycle later
        if (regRead) begin
            if (regAddr == `A_DRIVE_RANGE) begin
                st_next.rdData = st_reg.driveRange;
            end else if (regAddr == `A_TIME_CONST) begin
                st_next.rdData = st_reg.timeConst;
            end else if (regAddr == `A_DIG_CFG) begin
                st_next.rdData = st_reg.digCfg;
            end else if (regAddr == `A_ALT_CFG) begin
                st_next.rdData = st_reg.altCfg;
            end else if (regAddr == `A_DRIVE_CFG) begin
                st_next.rdData = st_reg.drvCfg;
            end else if (regAddr == `A_STATUS) begin
                st_next.rdData = `REG_RST;
                st_next.rdData[`STATUS_LOST_BIT] =
                    st_reg.oscLost;
            end else if (regAddr == `A_REF_CYCLE_COUNT_LO) begin
                st_next.rdData = st_reg.ref_cycle_count[7:0];
            end else if (regAddr == `A_REF_CYCLE_COUNT_HI) begin
                st_next.rdData = st_reg.ref_cycle_count[15:8];
            end else if (regAddr == `A_OFFSET_LO) begin
                st_next.rdData = st_reg.offset[7:0];
            end else if (regAddr == `A_OFFSET_HI) begin
                st_next.rdData = st_reg.offset[15:8];
            end else if (regAddr == `A_HIRES_CFG) begin
                st_next.rdData = st_reg.hiresCfg;
            end else if (regAddr == `A_RESULT_LO) begin
                st_next.rdData = st_reg.hrResult[7:0];
            end else if (regAddr == `A_RESULT_MID) begin
                st_next.rdData = st_reg.hrResult[15:8];
            end else if (regAddr == `A_RESULT_HI) begin
                st_next.rdData = st_reg.hrResult[23:16];
            end else begin
                st_next.rdData = `REG_RST;
            end
        end

        // ----------------------------------------
        // reference clock presence
        // ----------------------------------------
        if (refEdge) begin
            st_next.refIdle    = 16'h0000;
            st_next.refPresent = 1'b1;
        end else if (st_reg.refIdle >= 16'(REF_TIMEOUT)) begin
            st_next.refPresent = 1'b0;
        end else begin
            st_next.refIdle = st_reg.refIdle + 16'h0001;
        end

        // ----------------------------------------
        // watchdog and oscillator restart
        // ----------------------------------------
        if (st_reg.kickCnt != 20'h00000) begin
            st_next.kickCnt = st_reg.kickCnt - 20'h00001;
        end

        if (!activeMode || sensEdge) begin
            st_next.wdCnt = 20'h00000;
        end else begin
            st_next.wdCnt = st_reg.wdCnt + 20'h00001;
        end

        // a returning edge clears the flag and blocks a watchdog loss in the same cycle
        if (sensEdge) begin
            st_next.oscLost = 1'b0;
        end

        // ----------------------------------------
        // resistance+inductance conversion
        // ----------------------------------------
        if (!activeMode) begin
            st_next.rplCnt = 12'h000;
            st_next.rplRef = 16'h0000;
        end else begin
            if (refEdge) begin
                st_next.rplRef = st_reg.rplRef + 16'h0001;
            end
            if (sensEdge) begin
                if (st_reg.rplCnt >= rplLimit - 12'h001) begin
                    st_next.rplCnt  = 12'h000;
                    st_next.rplRef  = 16'h0000;
                    st_next.rplDone = 1'b1;
                    st_next.lResult = st_reg.rplRef;
                end else begin
                    st_next.rplCnt = st_reg.rplCnt + 12'h001;
                end
            end
        end

        // ----------------------------------------
        // high-resolution conversion
        // ----------------------------------------
        case (st_reg.hrState)
            inductive_conversion_control_pkg::HR_IDLE: begin
                st_next.hrRef  = 21'h000000;
                st_next.hrSens = 21'h000000;
                st_next.divCnt = 3'h0;
                // waits for active mode with the reference input marked present
                if (activeMode && st_reg.refPresent) begin
                    if (st_reg.ref_cycle_count == 16'h0000) begin
                        st_next.hrState =
                            inductive_conversion_control_pkg::HR_POST;
                    end else begin
                        st_next.hrState =
                            inductive_conversion_control_pkg::HR_COUNT;
                    end
                end
            end
            inductive_conversion_control_pkg::HR_COUNT: begin
                if (sensEdge) begin
                    if (st_reg.divCnt >= divMask) begin
                        st_next.divCnt = 3'h0;
                        st_next.hrSens = st_reg.hrSens + 21'h000001;
                    end else begin
                        st_next.divCnt = st_reg.divCnt + 3'h1;
                    end
                end
                if (refEdge) begin
                    if (st_reg.hrRef >= hrLimit - 21'h000001) begin
                        st_next.hrRef   = 21'h000000;
                        st_next.hrState =
                            inductive_conversion_control_pkg::HR_POST;
                    end else begin
                        st_next.hrRef = st_reg.hrRef + 21'h000001;
                    end
                end
            end
            inductive_conversion_control_pkg::HR_POST: begin
                if (refEdge) begin
                    if (st_reg.hrRef >= 21'(`HR_POST_CYC - 1)) begin
                        st_next.hrState =
                            inductive_conversion_control_pkg::HR_IDLE;
                        st_next.hrResult = hrValue;
                        st_next.hrDone   = 1'b1;
                    end else begin
                        st_next.hrRef = st_reg.hrRef + 21'h000001;
                    end
                end
            end
            default: begin
                st_next.hrState =
                    inductive_conversion_control_pkg::HR_IDLE;
            end
        endcase

        if (!activeMode) begin
            st_next.hrState =
                inductive_conversion_control_pkg::HR_IDLE;
        end

        // loss overrides every conversion in flight
        if (wdFire) begin
            st_next.oscLost  = 1'b1;
            st_next.wdCnt    = 20'h00000;
            st_next.kickCnt  = kickLen;
            st_next.rplCnt   = 12'h000;
            st_next.rplRef   = 16'h0000;
            st_next.rplDone  = 1'b0;
            st_next.hrDone   = 1'b0;
            st_next.hrState  =
                inductive_conversion_control_pkg::HR_IDLE;
            st_next.hrResult = `RESULT_LOST;
        end

        // without a reference both inductance paths read zero
        if (!st_reg.refPresent) begin
            st_next.lResult  = 16'h0000;
            st_next.hrResult = `RESULT_NONE;
            st_next.hrState  =
                inductive_conversion_control_pkg::HR_IDLE;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.sensSync1  <= 1'b0;
            st_reg.sensSync2  <= 1'b0;
            st_reg.sensPrev   <= 1'b0;
            st_reg.refSync1   <= 1'b0;
            st_reg.refSync2   <= 1'b0;
            st_reg.refPrev    <= 1'b0;
            st_reg.driveRange <= `REG_RST;
            st_reg.timeConst  <= `REG_RST;
            st_reg.digCfg     <= `REG_RST;
            st_reg.altCfg     <= `REG_RST;
            st_reg.drvCfg     <= `REG_RST;
            st_reg.ref_cycle_count     <= 16'h0000;
            st_reg.offset     <= 16'h0000;
            st_reg.hiresCfg   <= `REG_RST;
            st_reg.oscLost    <= 1'b0;
            st_reg.wdCnt      <= 20'h00000;
            st_reg.kickCnt    <= 20'h00000;
            st_reg.refIdle    <= 16'h0000;
            st_reg.refPresent <= 1'b0;
            st_reg.rplCnt     <= 12'h000;
            st_reg.rplRef     <= 16'h0000;
            st_reg.lResult    <= 16'h0000;
            st_reg.rplDone    <= 1'b0;
            st_reg.hrState    <=
                inductive_conversion_control_pkg::HR_IDLE;
            st_reg.hrRef      <= 21'h000000;
            st_reg.hrSens     <= 21'h000000;
            st_reg.divCnt     <= 3'h0;
            st_reg.hrResult   <= `RESULT_NONE;
            st_reg.hrDone     <= 1'b0;
            st_reg.rdData     <= `REG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign regRdData       = st_reg.rdData;
    assign oscLost         = st_reg.oscLost;
    assign oscRestart      = st_reg.kickCnt == kickLen
                             && st_reg.kickCnt != 20'h00000;
    assign oscKick         = st_reg.kickCnt != 20'h00000;
    assign rpModEnable     = ~fixedMode;
    assign driveCode       = st_reg.driveRange[2:0];
    assign highQualityTank = st_reg.driveRange[`HQ_TANK_BIT];
    assign tc1Res          = st_reg.timeConst[4:0];
    assign tc2Res          = st_reg.timeConst[5:0];
    assign tcCap           = st_reg.timeConst[7:6];
    assign rplDone         = st_reg.rplDone;
    assign lResult         = st_reg.lResult;
    assign hiresDone       = st_reg.hrDone;
    assign hiresResult     = st_reg.hrResult;

endmodule : inductive_conversion_control

// File: inductive_conversion_control_assertions.sv
// checker for the conversion-control block
// assumes only the top ports are visible; config writes are shadowed here
`timescale 1ns/10ps
module inductive_conversion_control_assertions (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    input wire logic        oscLost,
    input wire logic        oscRestart,
    input wire logic        oscKick,
    input wire logic        rpModEnable,
    input wire logic [2:0]  driveCode,
    input wire logic [4:0]  tc1Res,
    input wire logic [1:0]  tcCap,
    input wire logic        rplDone,
    input wire logic        hiresDone,
    input wire logic [23:0] hiresResult
);
    // ----------------------------------------
    // shadow registers
    // ----------------------------------------
    logic [7:0]  rngS;
    logic [7:0]  tcS;
    logic        fxS;
    logic        okS;
    logic        lostPrev;
    logic [23:0] resPrev;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rngS <= 8'h00;
            tcS <= 8'h00;
            fxS <= 1'b0;
            okS <= 1'b0;
            lostPrev <= 1'b0;
            resPrev <= 24'h000000;
        end else begin
            lostPrev <= oscLost;
            resPrev <= hiresResult;
            if (regWrite && regAddr == 8'h01) rngS <= regWrData;
            if (regWrite && regAddr == 8'h03) tcS <= regWrData;
            if (regWrite && regAddr == 8'h05) fxS <= regWrData[0];
            if (regWrite && regAddr == 8'h0C) okS <= regWrData[0];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    rp_mod_a: assert property (rpModEnable == !(fxS && okS))
        else $error("modulation enable wrong");
    drive_code_a: assert property (driveCode == rngS[2:0])
        else $error("drive code wrong");
    tc_fields_a: assert property (tc1Res == tcS[4:0] && tcCap == tcS[7:6])
        else $error("time constant fields wrong");
    lost_kick_a: assert property ($rose(oscLost) |-> ##[0:1] (oscRestart && oscKick))
        else $error("no restart on loss");
    restart_pulse_a: assert property (oscRestart |=> !oscRestart)
        else $error("restart pulse too long");
    lost_result_a: assert property ($rose(oscLost) |-> ##[0:1]
        (hiresResult == 24'hFFFFFF || hiresResult == 24'h000000))
        else $error("result not forced on loss");
    status_read_a: assert property (regRead && regAddr == 8'h20 |=>
        regRdData == {lostPrev, 7'h00}) else $error("status read wrong");
    result_lo_a: assert property (regRead && regAddr == 8'h38 |=>
        regRdData == resPrev[7:0]) else $error("result low byte wrong");
    result_hi_a: assert property (regRead && regAddr == 8'h3A |=>
        regRdData == resPrev[23:16]) else $error("result high byte wrong");
    rpl_pulse_a: assert property (rplDone |=> !rplDone)
        else $error("conversion done too long");
    hires_pulse_a: assert property (hiresDone |=> !hiresDone)
        else $error("hires done too long");

    cover property ($rose(oscLost));
    cover property (rplDone);
    cover property (hiresDone);
endmodule : inductive_conversion_control_assertions

// File: tank_ref_model.sv
// sensor tank and reference clock source
// assumes enables from the bench; phases offset from the system clock
`timescale 1ns/10ps
module tank_ref_model (
    input  wire logic sensOn,
    input  wire logic refOn,
    output logic      sensorOsc = 1'b0,
    output logic      refClkIn = 1'b0
);
    // stopped tank rests low; unused reference pin is tied to ground
    initial begin
        #1.3;
        forever begin
            #20;
            sensorOsc = sensOn ? ~sensorOsc : 1'b0;
        end
    end
    initial begin
        #2.1;
        forever begin
            #10;
            refClkIn = refOn ? ~refClkIn : 1'b0;
        end
    end
endmodule : tank_ref_model

// File: tb.sv
// self-checking bench for the conversion-control block
// assumes sensor period 8 clocks, reference period 4 clocks
`timescale 1ns/10ps
module tb;
    logic        clk_sys = 1'b0, arst_n = 1'b0, activeMode = 1'b0;
    logic        sensOn = 1'b1, refOn = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, b0, b1, b2;
    logic        oscLost, oscRestart, oscKick, rpModEnable, highQualityTank;
    logic        rplDone, hiresDone, sensorOsc, refClkIn;
    logic [2:0]  driveCode;
    logic [4:0]  tc1Res;
    logic [5:0]  tc2Res;
    logic [1:0]  tcCap;
    logic [15:0] lResult;
    logic [23:0] hiresResult;
    logic [7:0]  mdl [256];
    logic [7:0]  rw [10] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0C, 8'h30, 8'h31,
                             8'h32, 8'h33, 8'h34};
    logic [7:0]  ro [5] = '{8'h20, 8'h38, 8'h39, 8'h3A, 8'h02};
    logic [3:0]  mf [2] = '{4'hC, 4'h8};
    int          rs [3] = '{0, 3, 7};
    int          err_count = 0, checks = 0, n, e;

    always #2.5 clk_sys = ~clk_sys;

    inductive_conversion_control #(.WDOG_UNIT(8), .KICK_UNIT(4), .REF_TIMEOUT(20)) DUT (
        .clk_sys, .arst_n, .activeMode, .sensorOsc, .refClkIn, .regAddr, .regWrData,
        .regWrite, .regRead, .regRdData, .oscLost, .oscRestart, .oscKick, .rpModEnable,
        .driveCode, .highQualityTank, .tc1Res, .tc2Res, .tcCap, .rplDone, .lResult,
        .hiresDone, .hiresResult);
    tank_ref_model partner (.sensOn, .refOn, .sensorOsc, .refClkIn);

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic near(input logic [23:0] got, input int exp, input int tol);
        checks++;
        if (^got === 1'bx || int'(got) < exp - tol || int'(got) > exp + tol) begin
            err_count++;
            $display("FAIL %0t got %0d near %0d", $time, got, exp);
        end
    endtask : near

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        d = regRdData;
    endtask : rd

    // bounded wait: 0 rplDone, 1 hiresDone, 2 loss raised, 3 loss cleared
    task automatic wait_ev(input int sel, input int bound, output int c);
        logic hit;
        c = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clk_sys);
            #1;
            c++;
            case (sel)
                0: hit = rplDone === 1'b1;
                1: hit = hiresDone === 1'b1;
                2: hit = oscLost === 1'b1;
                default: hit = oscLost === 1'b0;
            endcase
            if (!hit && c >= bound) begin
                err_count++;
                $display("FAIL %0t wait ran out", $time);
                finish_test();
            end
        end
    endtask : wait_ev

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h693af49c));
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (rw[i]) begin
            rd(rw[i], b0);
            cmp(b0, 0);
        end
        foreach (ro[i]) begin
            wr(ro[i], 8'hFF);
            rd(ro[i], b0);
            cmp(b0, 0);
        end
        foreach (rw[i]) begin
            mdl[rw[i]] = 8'($urandom);
            wr(rw[i], mdl[rw[i]]);
        end
        foreach (rw[i]) begin
            rd(rw[i], b0);
            cmp(b0, mdl[rw[i]]);
        end
        wr(8'h01, 8'h85);
        wr(8'h03, 8'hE9);
        // outputs follow the write edge; look once they have settled
        @(negedge clk_sys);
        cmp({driveCode, highQualityTank}, 4'hB);
        cmp({tcCap, tc2Res, tc1Res}, 13'h1D29);
        for (int i = 3; i >= 0; i--) begin
            wr(8'h05, 8'(i & 1));
            wr(8'h0C, 8'(i >> 1));
            @(negedge clk_sys);
            cmp(rpModEnable, i != 3);
        end
        // short count trades resolution for run time
        wr(8'h30, 8'h08);
        wr(8'h31, 8'h00);
        wr(8'h32, 8'h01);
        wr(8'h33, 8'h00);
        activeMode <= 1'b1;
        foreach (rs[i]) begin
            wr(8'h04, 8'(rs[i]));
            e = 512 << (rs[i] > 5 ? 5 : rs[i]);
            wait_ev(0, 20000, n);
            wait_ev(0, 20000, n);
            near(24'(n), e, 12);
            near(24'(lResult), e / 4, 3);
        end
        for (int d = 0; d < 2; d++) begin
            wr(8'h34, 8'(d));
            wait_ev(1, 2000, n);
            wait_ev(1, 2000, n);
            // 16 * 8 + 55 reference periods of 4 clocks each
            near(24'(n), 732, 8);
            // sensor edges are counted only over the 16 * count window
            near(hiresResult, (64 >> d) * 16 - 256, 24);
            rd(8'h38, b0);
            rd(8'h39, b1);
            rd(8'h3A, b2);
            cmp({b2, b1, b0}, hiresResult);
        end
        foreach (mf[i]) begin
            wr(8'h04, {mf[i], 4'h0});
            sensOn <= 1'b0;
            wait_ev(2, 400, n);
            near(24'(n), 8 * (16 - mf[i]), 6);
            n = 0;
            while (oscKick === 1'b1 && n < 100) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            near(24'(n), 4 * (16 - mf[i]), 3);
            cmp(hiresResult, 24'hFFFFFF);
            rd(8'h20, b0);
            cmp(b0, 8'h80);
            sensOn <= 1'b1;
            wait_ev(3, 60, n);
        end
        wr(8'h04, 8'h00);
        refOn <= 1'b0;
        wait_ev(0, 2000, n);
        wait_ev(0, 2000, n);
        cmp(lResult, 0);
        cmp(hiresResult, 0);
        n = 0;
        repeat (600) begin
            @(posedge clk_sys);
            #1;
            if (hiresDone === 1'b1) n++;
        end
        cmp(24'(n), 0);
        finish_test();
    end
endmodule : tb

bind inductive_conversion_control inductive_conversion_control_assertions chk (
    .clk_sys, .arst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .oscLost,
    .oscRestart, .oscKick, .rpModEnable, .driveCode, .tc1Res, .tcCap, .rplDone,
    .hiresDone, .hiresResult);
